// *** pkg/fmcs_regs.svh ***
// Register offsets, field positions, reset values and the operation summary.
// Summary of operation
// - Mode field writable only with override set
// - Strap mode captured on power-down input rise
// - Mode-latched flag reads zero until capture
// - Mode codes: sync, external, internal, parallel
// - Lock auto-loads raw10 parallel bit unless blocked
// - Lock auto-loads raw12 parallel bit unless blocked
// - Lock enable keeps software parallel bit values
// - Divider code divides reference clock 1,2,4,8
// - Range bit picks 25 or 50 MHz oscillator
// - Internal reference in internal mode or no clock
`ifndef FMCS_REGS_SVH
`define FMCS_REGS_SVH
`define FMCS_ADDR_MODE 8'h03
`define FMCS_ADDR_LEGACY 8'h04
`define FMCS_ADDR_REFCLK 8'h05
`define FMCS_MODE_LSB 0
`define FMCS_MODE_MSB 2
`define FMCS_DONE_BIT 3
`define FMCS_OV_BIT 4
`define FMCS_RAW10_BIT 2
`define FMCS_RAW12_BIT 1
`define FMCS_LOCK_EN_BIT 0
`define FMCS_DIV_LSB 4
`define FMCS_DIV_MSB 6
`define FMCS_OSC_BIT 3
`define FMCS_MODE_RSV_MASK 8'hA0
`define FMCS_LEGACY_RSV_MASK 8'hF8
`define FMCS_REFCLK_RSV_MASK 8'h87
`define FMCS_REFCLK_RSV_RESET 8'h03
`define FMCS_DIV_MAX_CODE 3'h3
`endif

// *** pkg/fmcs_pkg.sv ***
// Types shared by the mode and reference clock select block.
package fmcs_pkg;
  typedef enum logic [2:0] {
    FMCS_MODE_CSI_SYNC = 3'b000,
    FMCS_MODE_RSV1 = 3'b001,
    FMCS_MODE_CSI_EXT_CLK = 3'b010,
    FMCS_MODE_CSI_INT_CLK = 3'b011,
    FMCS_MODE_RSV4 = 3'b100,
    FMCS_MODE_PARALLEL_EXT = 3'b101,
    FMCS_MODE_RSV6 = 3'b110,
    FMCS_MODE_RSV7 = 3'b111
  } fmcs_mode_t;
endpackage

// *** src/fmcs_ref_div.sv ***
// Divides synchronised reference clock edges into an internal reference tick.
`timescale 1ns/1ns
`include "fmcs_regs.svh"
module fmcs_ref_div (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ref_rise,
  input wire logic [2:0] div_code,
  output logic tick_r
);
  logic [2:0] cnt_r;

  // Reserved codes fall back to divide by one so the tick never stops.
  function automatic logic [2:0] div_limit(input logic [2:0] code);
    unique case (code)
      3'h1: div_limit = 3'h1;
      3'h2: div_limit = 3'h3;
      3'h3: div_limit = 3'h7;
      default: div_limit = 3'h0;
    endcase
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (ref_rise) begin
        if (cnt_r >= div_limit(div_code)) begin
          cnt_r <= 3'h0;
          tick_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 3'h1;
        end
      end
    end
  end
endmodule

// *** src/fmcs_top.sv ***
// Forward mode select, legacy parallel sub-mode and reference clock control.
`timescale 1ns/1ns
`include "fmcs_regs.svh"
module fmcs_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic power_down_input,
  input wire logic [2:0] mode_strap,
  input wire logic reference_clock_input,
  input wire logic sys_clk_present,
  input wire logic rx_lock,
  input wire logic bcc_raw10_value,
  input wire logic bcc_raw12_value,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  output logic reg_rvalid_r,
  output fmcs_pkg::fmcs_mode_t mode_out_r,
  output logic mode_done_r,
  output logic mode_reserved_r,
  output logic local_clk_needed_r,
  output logic raw10_parallel_select,
  output logic raw12_hf_parallel_select,
  output logic parallel_mode_lock_enable,
  output logic [2:0] ref_input_divider,
  output logic osc_range_select,
  output logic use_internal_ref_r,
  output logic int_ref_tick_r
);
  logic [2:0] pd_sync_r;
  logic [2:0] ref_sync_r;
  logic [1:0] sys_sync_r;
  logic [2:0] strap_meta_r;
  logic [2:0] strap_sync_r;
  logic [2:0] strap_cap_r;
  logic mode_strap_override;
  logic [2:0] mode_wr_r;
  logic [2:0] mode_rsv_r;
  logic [4:0] legacy_rsv_r;
  logic [3:0] refclk_rsv_r;
  logic rx_lock_d_r;
  logic pd_rise;
  logic ref_rise;
  logic lock_rise;
  logic wr_mode;
  logic wr_legacy;
  logic wr_refclk;
  logic [2:0] mode_eff;
  logic lock_block;

  // A register is hit only on an exact offset match.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign wr_mode = reg_wr && hit(reg_addr, `FMCS_ADDR_MODE);
  assign wr_legacy = reg_wr && hit(reg_addr, `FMCS_ADDR_LEGACY);
  assign wr_refclk = reg_wr && hit(reg_addr, `FMCS_ADDR_REFCLK);

  // These pins pass two flops; the power-down and reference edge detectors look only at the second stage on, rx_lock is used raw.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_sync_r <= 3'h0;
      ref_sync_r <= 3'h0;
      sys_sync_r <= 2'h0;
      strap_meta_r <= 3'h0;
      strap_sync_r <= 3'h0;
    end else begin
      pd_sync_r <= {pd_sync_r[1:0], power_down_input};
      ref_sync_r <= {ref_sync_r[1:0], reference_clock_input};
      sys_sync_r <= {sys_sync_r[0], sys_clk_present};
      strap_meta_r <= mode_strap;
      strap_sync_r <= strap_meta_r;
    end
  end

  assign pd_rise = pd_sync_r[1] && !pd_sync_r[2];
  assign ref_rise = ref_sync_r[1] && !ref_sync_r[2];
  assign lock_rise = rx_lock && !rx_lock_d_r;

  // The strap is taken on the low to high edge of the power-down input.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cap_r <= 3'h0;
    end else if (pd_rise) begin
      strap_cap_r <= strap_sync_r;
    end
  end

  // The flag rises in the same cycle as the capture and drops in power down.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_done_r <= 1'b0;
    end else if (pd_rise) begin
      mode_done_r <= 1'b1;
    end else if (!pd_sync_r[1]) begin
      mode_done_r <= 1'b0;
    end
  end

  // Mode register: override bit, written mode and reserved storage.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_strap_override <= 1'b0;
      mode_wr_r <= 3'h0;
      mode_rsv_r <= 3'h0;
    end else if (wr_mode) begin
      mode_strap_override <= reg_wdata[`FMCS_OV_BIT];
      mode_rsv_r <= {reg_wdata[7], 1'b0, reg_wdata[5]};
      if (reg_wdata[`FMCS_OV_BIT]) begin
        mode_wr_r <= reg_wdata[`FMCS_MODE_MSB:`FMCS_MODE_LSB];
      end
    end
  end

  assign mode_eff = mode_strap_override ? mode_wr_r : strap_cap_r;

  // Decoded mode outputs are registered so each output leaves a flop.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_out_r <= fmcs_pkg::FMCS_MODE_CSI_SYNC;
      mode_reserved_r <= 1'b0;
      local_clk_needed_r <= 1'b0;
      use_internal_ref_r <= 1'b0;
    end else begin
      mode_out_r <= fmcs_pkg::fmcs_mode_t'(mode_eff);
      unique case (fmcs_pkg::fmcs_mode_t'(mode_eff))
        fmcs_pkg::FMCS_MODE_CSI_SYNC,
        fmcs_pkg::FMCS_MODE_CSI_INT_CLK: begin
          mode_reserved_r <= 1'b0;
          local_clk_needed_r <= 1'b0;
        end
        fmcs_pkg::FMCS_MODE_CSI_EXT_CLK,
        fmcs_pkg::FMCS_MODE_PARALLEL_EXT: begin
          mode_reserved_r <= 1'b0;
          local_clk_needed_r <= 1'b1;
        end
        default: begin
          mode_reserved_r <= 1'b1;
          local_clk_needed_r <= 1'b0;
        end
      endcase
      use_internal_ref_r <= (mode_eff == fmcs_pkg::FMCS_MODE_CSI_INT_CLK)
                            || !sys_sync_r[1];
    end
  end

  // A write that turns the lock on in this cycle also blocks the load.
  assign lock_block = parallel_mode_lock_enable ||
                      (wr_legacy && reg_wdata[`FMCS_LOCK_EN_BIT]);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_lock_d_r <= 1'b0;
    end else begin
      rx_lock_d_r <= rx_lock;
    end
  end

  // Without the lock, the control channel load beats a same-cycle write.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw10_parallel_select <= 1'b0;
      raw12_hf_parallel_select <= 1'b0;
      parallel_mode_lock_enable <= 1'b0;
      legacy_rsv_r <= 5'h00;
    end else begin
      if (wr_legacy) begin
        parallel_mode_lock_enable <= reg_wdata[`FMCS_LOCK_EN_BIT];
        legacy_rsv_r <= reg_wdata[7:3];
      end
      if (lock_rise && !lock_block) begin
        raw10_parallel_select <= bcc_raw10_value;
        raw12_hf_parallel_select <= bcc_raw12_value;
      end else if (wr_legacy) begin
        raw10_parallel_select <= reg_wdata[`FMCS_RAW10_BIT];
        raw12_hf_parallel_select <= reg_wdata[`FMCS_RAW12_BIT];
      end
    end
  end

  // Reference clock control register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_input_divider <= 3'h0;
      osc_range_select <= 1'b0;
      refclk_rsv_r <= {1'b0, 3'(`FMCS_REFCLK_RSV_RESET)};
    end else if (wr_refclk) begin
      ref_input_divider <= reg_wdata[`FMCS_DIV_MSB:`FMCS_DIV_LSB];
      osc_range_select <= reg_wdata[`FMCS_OSC_BIT];
      refclk_rsv_r <= {reg_wdata[7], reg_wdata[2:0]};
    end
  end

  fmcs_ref_div u_ref_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ref_rise(ref_rise),
    .div_code(ref_input_divider),
    .tick_r(int_ref_tick_r)
  );

  // Read data appear one cycle after the strobe; unmapped offsets read 0.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        if (hit(reg_addr, `FMCS_ADDR_MODE)) begin
          reg_rdata_r <= {mode_rsv_r[2], mode_rsv_r[1], mode_rsv_r[0],
                          mode_strap_override, mode_done_r, mode_eff};
        end else if (hit(reg_addr, `FMCS_ADDR_LEGACY)) begin
          reg_rdata_r <= {legacy_rsv_r, raw10_parallel_select,
                          raw12_hf_parallel_select,
                          parallel_mode_lock_enable};
        end else if (hit(reg_addr, `FMCS_ADDR_REFCLK)) begin
          reg_rdata_r <= {refclk_rsv_r[3], ref_input_divider,
                          osc_range_select, refclk_rsv_r[2:0]};
        end else begin
          reg_rdata_r <= 8'h00;
        end
      end
    end
  end
endmodule

// *** dv/fmcs_top_properties.sv ***
// Port assertions for the mode and reference clock select block.
`timescale 1ns/1ns
module fmcs_top_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic power_down_input,
  input wire logic rx_lock,
  input wire logic bcc_raw10_value,
  input wire logic bcc_raw12_value,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire fmcs_pkg::fmcs_mode_t mode_out_r,
  input wire logic mode_done_r,
  input wire logic mode_reserved_r,
  input wire logic raw10_parallel_select,
  input wire logic raw12_hf_parallel_select,
  input wire logic parallel_mode_lock_enable,
  input wire logic use_internal_ref_r,
  input wire logic int_ref_tick_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_done_rise; $rose(mode_done_r) |-> $past(power_down_input, 2);
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("done early");
  property p_done_low; !power_down_input [*4] |-> !mode_done_r; endproperty
  a_done_low: assert property (p_done_low) else $error("done stuck");
  property p_ovr; reg_wr && reg_addr == 8'h03 && reg_wdata[4] ##1 !reg_wr
    |=> mode_out_r == $past(reg_wdata[2:0], 2); endproperty
  a_ovr: assert property (p_ovr) else $error("override mode");
  property p_rsv; $stable(mode_out_r) ##1 $stable(mode_out_r)
    |-> mode_reserved_r == (mode_out_r inside {3'h1, 3'h4, 3'h6, 3'h7});
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag");
  property p_int; (mode_out_r == 3'h3) [*2] |-> use_internal_ref_r;
  endproperty
  a_int: assert property (p_int) else $error("internal ref");
  property p_load; $rose(rx_lock) && !parallel_mode_lock_enable && !reg_wr
    |=> {raw10_parallel_select, raw12_hf_parallel_select}
      == $past({bcc_raw10_value, bcc_raw12_value}); endproperty
  a_load: assert property (p_load) else $error("auto load");
  property p_keep; parallel_mode_lock_enable && !reg_wr
    |=> $stable({raw10_parallel_select, raw12_hf_parallel_select});
  endproperty
  a_keep: assert property (p_keep) else $error("locked bits");
  property p_tick; int_ref_tick_r |=> !int_ref_tick_r; endproperty
  a_tick: assert property (p_tick) else $error("tick width");
  c_done: cover property ($rose(mode_done_r));
  c_load: cover property ($rose(rx_lock) && !parallel_mode_lock_enable);
  c_int: cover property (use_internal_ref_r && int_ref_tick_r);
endmodule
bind fmcs_top fmcs_top_properties u_fmcs_top_properties (.*);

// *** dv/fmcs_bcc_model.sv ***
// Control channel model that raises receive lock and offers sub-mode bits.
`timescale 1ns/1ns
module fmcs_bcc_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic lock_req,
  input wire logic v10,
  input wire logic v12,
  output logic rx_lock,
  output logic bcc_raw10_value,
  output logic bcc_raw12_value
);
  // Without lock the values toggle, so a design reading them then is caught.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {rx_lock, bcc_raw10_value, bcc_raw12_value} <= 3'h0;
    end else begin
      rx_lock <= lock_req;
      bcc_raw10_value <= lock_req ? v10 : !bcc_raw10_value;
      bcc_raw12_value <= lock_req ? v12 : !bcc_raw12_value;
    end
  end
endmodule

// *** dv/fmcs_top_test.sv ***
// Self-checking bench for the mode and reference clock select block.
`timescale 1ns/1ns
module fmcs_top_test;
  logic ref_clk, rst_n, power_down_input, sys_clk_present, reg_wr, reg_rd;
  logic reference_clock_input, rx_lock, bcc_raw10_value, bcc_raw12_value;
  logic lock_req, v10, v12, mode_reserved_r, local_clk_needed_r;
  logic use_internal_ref_r, int_ref_tick_r, osc_range_select;
  logic reg_rvalid_r, mode_done_r, raw10_parallel_select;
  logic raw12_hf_parallel_select, parallel_mode_lock_enable;
  logic [2:0] mode_strap, rc, m, ref_input_divider;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, d, e;
  fmcs_pkg::fmcs_mode_t mode_out_r;
  int bad_count = 0, cmp_count = 0, cyc = 0, n;
  assign reference_clock_input = rc[2];
  fmcs_top u_fmcs_top (.*);
  fmcs_bcc_model u_fmcs_bcc_model (.*);
  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_r;
    chk("read valid", 8'h01, {7'h00, reg_rvalid_r});
  endtask
  task automatic lock(input logic on, input logic [1:0] v);
    @(posedge ref_clk);
    {v10, v12, lock_req} <= {v, on};
    repeat (3) @(posedge ref_clk);
  endtask
  function automatic logic [2:0] flags(input logic [2:0] c);
    return {c inside {3'h1, 3'h4, 3'h6, 3'h7}, c == 3'h2 || c == 3'h5,
      c == 3'h3};
  endfunction
  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) rc <= rc + 3'h1;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h4aff_5343));
    {ref_clk, rst_n, power_down_input, reg_wr, reg_rd, lock_req} = '0;
    {reg_addr, reg_wdata, rc, v10, v12} = '0;
    sys_clk_present = 1'b1;
    mode_strap = 3'($urandom);
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h05);
    chk("refclk reset", 8'h03, d);
    rd(8'h04);
    chk("legacy reset", 8'h00, d);
    rd(8'h03);
    chk("done before capture", 8'h00, d & 8'h08);
    power_down_input <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(8'h03);
    chk("strap capture", {5'h01, mode_strap}, d);
    wr(8'h03, {5'h00, ~mode_strap});
    rd(8'h03);
    chk("mode locked", {5'h01, mode_strap}, d);
    // Every code, with reserved and read-only bits written high as well.
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wr(8'h03, {3'h7, 2'h3, m});
      rd(8'h03);
      chk("mode override", {3'h5, 2'h3, m}, d);
      chk("mode flags", {m, 2'h0, flags(m)}, {mode_out_r, 2'h0,
        mode_reserved_r, local_clk_needed_r, use_internal_ref_r});
    end
    wr(8'h07, 8'hff);
    rd(8'h07);
    chk("unmapped", 8'h00, d);
    lock(1'b1, 2'($urandom));
    rd(8'h04);
    chk("auto load", {5'h00, v10, v12, 1'b0}, d);
    lock(1'b0, {v10, v12});
    e = {5'h00, ~v10, ~v12, 1'b1};
    wr(8'h04, e);
    // The channel offers the opposite bits, so a stray load shows up.
    lock(1'b1, ~e[2:1]);
    rd(8'h04);
    chk("locked bits", e, d);
    chk("sub-mode pins", e, {5'h00, raw10_parallel_select,
      raw12_hf_parallel_select, parallel_mode_lock_enable});
    // Code 4 is reserved and is expected to run as divide by one.
    for (int c = 0; c < 5; c++) begin
      e = {1'($urandom), 3'(c), 1'($urandom), 3'($urandom)};
      wr(8'h05, e);
      rd(8'h05);
      chk("refclk ctrl", e, d);
      chk("osc range", {7'h00, e[3]}, {7'h00, osc_range_select});
      chk("divider", {5'h00, e[6:4]}, {5'h00, ref_input_divider});
      repeat (64) @(posedge ref_clk);
      n = 0;
      repeat (512) begin
        @(posedge ref_clk);
        #1 n += int_ref_tick_r;
      end
      chk("tick count", 8'(c < 4 ? 64 >> c : 64), 8'(n));
    end
    @(posedge ref_clk);
    sys_clk_present <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("no sys clk", 8'h01, {7'h00, use_internal_ref_r});
    // Power down again and capture a new strap on the next rise.
    power_down_input <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("done cleared", 8'h00, {7'h00, mode_done_r});
    mode_strap <= ~mode_strap;
    repeat (4) @(posedge ref_clk);
    power_down_input <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("done set", 8'h01, {7'h00, mode_done_r});
    wr(8'h03, 8'h00);
    rd(8'h03);
    chk("strap recapture", {5'h01, mode_strap}, d);
    end_of_test();
  end
endmodule
